// >>> verilog/ppc_pkg.sv
// Purpose: constants and carriers for the six-pin pad control block
// Assumes: APB slave, 32-bit data, byte addresses, 8-bit registers
// Notes: reset values are all zero, so every pin but output-only pin 4 comes up as a plain input
// Contract
// - one pullup enable bit per pin
// - pullup off while pin drives output
// - pullup off under analog control
// - pullup bit 4 has no effect
// - slew bit per pin limits transitions
// - slew has no effect on inputs
// - slew bit 5 has no effect
// - drive bit per pin selects high drive
// - drive select no effect on inputs
// - drive bit 5 has no effect
// - direction bit enables pin output buffer
// - analog function disables both pin buffers
// - reset leaves pins high-impedance, pullups off
package ppc_pkg;

  localparam int PPC_PINS = 6;
  localparam int PPC_REG_W = 8;
  localparam int PPC_ADDR_W = 8;

  // pin roles
  localparam int PPC_OUT_ONLY_PIN = 4;
  localparam int PPC_IN_ONLY_PIN = 5;

  // register byte offsets
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_DATA = 8'h00;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_DIRECTION = 8'h04;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_PULLUP = 8'h08;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_SLEW = 8'h0C;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_DRIVE = 8'h10;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_EFF_PULLUP = 8'h14;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_EFF_SLEW = 8'h18;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_EFF_DRIVE = 8'h1C;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_EFF_OUT = 8'h20;

  // reset values
  localparam logic [PPC_PINS-1:0] PPC_RST_DATA = 6'h00;
  localparam logic [PPC_PINS-1:0] PPC_RST_DIRECTION = 6'h00;
  localparam logic [PPC_PINS-1:0] PPC_RST_PULLUP = 6'h00;
  localparam logic [PPC_PINS-1:0] PPC_RST_SLEW = 6'h00;
  localparam logic [PPC_PINS-1:0] PPC_RST_DRIVE = 6'h00;
  localparam logic [31:0] PPC_RST_RDATA = 32'h0000_0000;

  // effective pad controls, one bit per pin
  typedef struct packed {
    logic [PPC_PINS-1:0] pull_on;
    logic [PPC_PINS-1:0] slew;
    logic [PPC_PINS-1:0] drive_hi;
    logic [PPC_PINS-1:0] out_en;
    logic [PPC_PINS-1:0] in_en;
    logic [PPC_PINS-1:0] out_val;
  } ppc_pad_type;

  // shared functions that may own a pin
  typedef struct packed {
    logic [PPC_PINS-1:0] analog_en;
    logic [PPC_PINS-1:0] periph_en;
    logic [PPC_PINS-1:0] periph_oe;
    logic [PPC_PINS-1:0] periph_out;
  } ppc_share_type;

endpackage : ppc_pkg

// >>> verilog/ppc_pad_bit.sv
// Purpose: effective pad controls of one pin
// Assumes: purely combinational; the top registers the results
// Notes: pin capabilities are fixed by parameters
`timescale 1ns/1ns
module ppc_pad_bit
#(
  parameter bit CAN_IN = 1'b1,
  parameter bit CAN_OUT = 1'b1
)
(
  input wire logic dir,
  input wire logic pullup_en,
  input wire logic slew_en,
  input wire logic drive_sel,
  input wire logic data,
  input wire logic analog_en,
  input wire logic periph_en,
  input wire logic periph_oe,
  input wire logic periph_out,
  output logic pull_on,
  output logic slew,
  output logic drive_hi,
  output logic out_en,
  output logic in_en,
  output logic out_val
);

  logic drive_req;

  // a shared digital function takes the output buffer from the direction bit
  assign drive_req = periph_en ? periph_oe : dir;
  // analog owns the pin outright, even over a digital function
  assign out_en = CAN_OUT & ~analog_en & drive_req;
  assign in_en = CAN_IN & ~analog_en;
  assign out_val = periph_en ? periph_out : data;
  // an output-only pin has no pullup device at all
  assign pull_on = CAN_IN & pullup_en & ~out_en & ~analog_en;
  // slew and drive only shape a driven output
  assign slew = slew_en & out_en;
  assign drive_hi = drive_sel & out_en;

endmodule : ppc_pad_bit

// >>> verilog/ppc_top.sv
// Purpose: six-pin port with per-pin pullup, slew and drive control
// Assumes: APB slave, one access cycle, inputs synchronous to pclk
// Notes: pin 4 is output-only, pin 5 is input-only
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
module ppc_top
  import ppc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppc_share_type share,
  input wire logic [PPC_PINS-1:0] pin_in,
  output ppc_pad_type pad
);

  // stored controls
  logic [PPC_PINS-1:0] data_reg;
  logic [PPC_PINS-1:0] data_next;
  logic [PPC_PINS-1:0] pin_direction_reg;
  logic [PPC_PINS-1:0] pin_direction_next;
  logic [PPC_PINS-1:0] pin_pullup_enable_reg;
  logic [PPC_PINS-1:0] pin_pullup_enable_next;
  logic [PPC_PINS-1:0] pin_slew_enable_reg;
  logic [PPC_PINS-1:0] pin_slew_enable_next;
  logic [PPC_PINS-1:0] pin_drive_select_reg;
  logic [PPC_PINS-1:0] pin_drive_select_next;

  // bus answer
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // pad outputs
  ppc_pad_type pad_reg;
  ppc_pad_type pad_next;

  // decode
  logic setup_phase;
  logic access_done;
  logic wr_lane0;
  logic hit_data;
  logic hit_direction;
  logic hit_pullup;
  logic hit_slew;
  logic hit_drive;
  logic hit_eff_pullup;
  logic hit_eff_slew;
  logic hit_eff_drive;
  logic hit_eff_out;
  logic hit_rw;
  logic hit_ro;
  logic hit_any;
  logic bad_access;
  logic do_write;
  logic [PPC_PINS-1:0] wr_bits;

  // read side
  logic [PPC_PINS-1:0] data_view;
  logic [PPC_PINS-1:0] rd_bits;
  logic [PPC_PINS-1:0] dir_view;

  // per-pin results before registering
  logic [PPC_PINS-1:0] eff_pullup;
  logic [PPC_PINS-1:0] eff_slew;
  logic [PPC_PINS-1:0] eff_drive;
  logic [PPC_PINS-1:0] eff_out_en;
  logic [PPC_PINS-1:0] eff_in_en;
  logic [PPC_PINS-1:0] eff_out_val;

  // the answer is prepared in the setup cycle so prdata comes from a flop
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;

  assign hit_data = (paddr == PPC_OFF_DATA);
  assign hit_direction = (paddr == PPC_OFF_DIRECTION);
  assign hit_pullup = (paddr == PPC_OFF_PULLUP);
  assign hit_slew = (paddr == PPC_OFF_SLEW);
  assign hit_drive = (paddr == PPC_OFF_DRIVE);
  assign hit_eff_pullup = (paddr == PPC_OFF_EFF_PULLUP);
  assign hit_eff_slew = (paddr == PPC_OFF_EFF_SLEW);
  assign hit_eff_drive = (paddr == PPC_OFF_EFF_DRIVE);
  assign hit_eff_out = (paddr == PPC_OFF_EFF_OUT);

  assign hit_rw = hit_data | hit_direction | hit_pullup | hit_slew | hit_drive;
  assign hit_ro = hit_eff_pullup | hit_eff_slew | hit_eff_drive | hit_eff_out;
  assign hit_any = hit_rw | hit_ro;

  // unmapped addresses and writes to status words are refused
  assign bad_access = ~hit_any | (pwrite & hit_ro);

  // only lane 0 carries register bits; bits 6 and 7 are dropped
  assign wr_lane0 = pstrb[0];
  assign wr_bits = pwdata[PPC_PINS-1:0];
  assign do_write = access_done & pwrite & ~pslverr_reg & wr_lane0;

  // an input-only pin has no direction bit to keep
  assign pin_direction_next = (do_write & hit_direction)
                              ? (wr_bits & ~(6'h01 << PPC_IN_ONLY_PIN))
                              : pin_direction_reg;
  assign data_next = (do_write & hit_data) ? wr_bits : data_reg;
  assign pin_pullup_enable_next = (do_write & hit_pullup) ? wr_bits : pin_pullup_enable_reg;
  assign pin_slew_enable_next = (do_write & hit_slew) ? wr_bits : pin_slew_enable_reg;
  assign pin_drive_select_next = (do_write & hit_drive) ? wr_bits : pin_drive_select_reg;

  // reads of an input return the pin, gated off when its buffer is off
  assign dir_view = pin_direction_reg;
  assign data_view = (dir_view & data_reg) | (~dir_view & pin_in & eff_in_en);

  assign rd_bits = hit_data ? data_view
                 : hit_direction ? pin_direction_reg
                 : hit_pullup ? pin_pullup_enable_reg
                 : hit_slew ? pin_slew_enable_reg
                 : hit_drive ? pin_drive_select_reg
                 : hit_eff_pullup ? pad_reg.pull_on
                 : hit_eff_slew ? pad_reg.slew
                 : hit_eff_drive ? pad_reg.drive_hi
                 : hit_eff_out ? pad_reg.out_en
                 : 6'h00;

  // upper register bits and the rest of the word read as zero
  assign prdata_next = (setup_phase & ~pwrite & ~bad_access)
                       ? {26'h000_0000, rd_bits}
                       : (access_done ? PPC_RST_RDATA : prdata_reg);
  assign pready_next = setup_phase;
  assign pslverr_next = setup_phase ? bad_access : (access_done ? 1'b0 : pslverr_reg);

  // per-pin gating, capabilities fixed by pin role
  genvar gi;
  generate
    for (gi = 0; gi < PPC_PINS; gi++)
    begin : g_pin
      ppc_pad_bit
      #(
        .CAN_IN(gi != PPC_OUT_ONLY_PIN),
        .CAN_OUT(gi != PPC_IN_ONLY_PIN)
      )
      u_bit
      (
        .dir(pin_direction_reg[gi]),
        .pullup_en(pin_pullup_enable_reg[gi]),
        .slew_en(pin_slew_enable_reg[gi]),
        .drive_sel(pin_drive_select_reg[gi]),
        .data(data_reg[gi]),
        .analog_en(share.analog_en[gi]),
        .periph_en(share.periph_en[gi]),
        .periph_oe(share.periph_oe[gi]),
        .periph_out(share.periph_out[gi]),
        .pull_on(eff_pullup[gi]),
        .slew(eff_slew[gi]),
        .drive_hi(eff_drive[gi]),
        .out_en(eff_out_en[gi]),
        .in_en(eff_in_en[gi]),
        .out_val(eff_out_val[gi])
      );
    end
  endgenerate

  // high drive on many pins is software's budget, not checked here
  assign pad_next.pull_on = eff_pullup;
  assign pad_next.slew = eff_slew;
  assign pad_next.drive_hi = eff_drive;
  assign pad_next.out_en = eff_out_en;
  assign pad_next.in_en = eff_in_en;
  assign pad_next.out_val = eff_out_val;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_reg <= PPC_RST_DATA;
      pin_direction_reg <= PPC_RST_DIRECTION;
      pin_pullup_enable_reg <= PPC_RST_PULLUP;
      pin_slew_enable_reg <= PPC_RST_SLEW;
      pin_drive_select_reg <= PPC_RST_DRIVE;
    end
    else
    begin
      data_reg <= data_next;
      pin_direction_reg <= pin_direction_next;
      pin_pullup_enable_reg <= pin_pullup_enable_next;
      pin_slew_enable_reg <= pin_slew_enable_next;
      pin_drive_select_reg <= pin_drive_select_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= PPC_RST_RDATA;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // pads come up undriven, pullups off, input buffers off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_reg <= '0;
    end
    else
    begin
      pad_reg <= pad_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pad = pad_reg;

endmodule : ppc_top

// >>> tb/ppc_chk.sv
// Purpose: port-level checks of the pad control block
// Assumes: pad outputs lag their causes by one edge
// Notes: bound into ppc_top
`timescale 1ns/1ns
module ppc_chk
  import ppc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ppc_share_type share,
  input wire logic [PPC_PINS-1:0] pin_in,
  input wire ppc_pad_type pad
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PU_OUT: assert property ((pad.pull_on & pad.out_en) == 6'h00)
    else $error("pullup on driven pin");
  AST_ANALOG: assert property (1'b1 |=> ((pad.pull_on | pad.out_en | pad.in_en) & $past(share.analog_en)) == 6'h00)
    else $error("analog pin not isolated");
  AST_PU4: assert property (!pad.pull_on[PPC_OUT_ONLY_PIN])
    else $error("pullup on output-only pin");
  AST_SLEW_IN: assert property ((pad.slew & ~pad.out_en) == 6'h00)
    else $error("slew on input pin");
  AST_SLEW5: assert property (!pad.slew[PPC_IN_ONLY_PIN])
    else $error("slew on input-only pin");
  AST_DRV_IN: assert property ((pad.drive_hi & ~pad.out_en) == 6'h00)
    else $error("drive on input pin");
  AST_DRV5: assert property (!pad.drive_hi[PPC_IN_ONLY_PIN] && !pad.out_en[PPC_IN_ONLY_PIN])
    else $error("drive on input-only pin");
  // reset is asynchronous, so this one must not be disabled by it
  AST_RST: assert property (disable iff (1'b0) !presetn |-> pad == '0)
    else $error("pad active in reset");
  AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not one cycle");
  AST_UPPER: assert property (pready && !pwrite |-> prdata[31:6] == 26'h000_0000)
    else $error("upper read bits set");
endmodule : ppc_chk

bind ppc_top ppc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .share(share), .pin_in(pin_in), .pad(pad));

// >>> tb/ppc_board.sv
// Purpose: board model of the six port pins
// Assumes: no external pulls on the board
// Notes: a floating pin toggles so no level is trusted
`timescale 1ns/1ns
module ppc_board
  import ppc_pkg::*;
(
  input wire logic pclk,
  input wire ppc_pad_type pad,
  output logic [PPC_PINS-1:0] pin_in
);
  logic [PPC_PINS-1:0] float_reg = 6'h15;
  always @(posedge pclk) float_reg <= ~float_reg;
  assign pin_in = (pad.out_en & pad.out_val) | (~pad.out_en & (pad.pull_on | float_reg));
endmodule : ppc_board

// >>> tb/ppc_top_tb_top.sv
// Purpose: register-level test of the pad control block
// Assumes: apb answers in the first access cycle
// Notes: pad checks wait one edge after the cause
`timescale 1ns/1ns
module ppc_top_tb_top
  import ppc_pkg::*;
;
  logic pclk = 1'b0;
  // starts unknown so the drop at time zero is a real reset edge
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PPC_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [3:0] strb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ppc_share_type share = '0;
  logic [PPC_PINS-1:0] pin_in;
  ppc_pad_type pad;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  ppc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .share(share), .pin_in(pin_in), .pad(pad));
  ppc_board u_board (.pclk(pclk), .pad(pad), .pin_in(pin_in));
  always #25 pclk = ~pclk;
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!wr) check("rdata", prdata, x);
    check("pslverr", 32'(pslverr), 32'(xe));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic pads(input logic [5:0] pu, oe, sl, dr, ie);
    @(posedge pclk);
    #1;
    check("pullup", 32'(pad.pull_on), 32'(pu));
    check("out_en", 32'(pad.out_en), 32'(oe));
    check("slew", 32'(pad.slew), 32'(sl));
    check("drive_hi", 32'(pad.drive_hi), 32'(dr));
    check("in_en", 32'(pad.in_en), 32'(ie));
  endtask : pads
  initial
  begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pads(6'h00, 6'h00, 6'h00, 6'h00, 6'h2F);
    for (int a = 4; a <= 32; a += 4) acc(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
    acc(1'b1, PPC_OFF_PULLUP, 32'hFFFF_FFFF, 32'h0, 1'b0);
    acc(1'b0, PPC_OFF_PULLUP, 32'h0, 32'h0000_003F, 1'b0);
    pads(6'h2F, 6'h00, 6'h00, 6'h00, 6'h2F);
    acc(1'b1, PPC_OFF_SLEW, 32'hFFFF_FFFF, 32'h0, 1'b0);
    acc(1'b1, PPC_OFF_DRIVE, 32'hFFFF_FFFF, 32'h0, 1'b0);
    pads(6'h2F, 6'h00, 6'h00, 6'h00, 6'h2F);
    acc(1'b1, PPC_OFF_DIRECTION, 32'h0000_000F, 32'h0, 1'b0);
    pads(6'h20, 6'h0F, 6'h0F, 6'h0F, 6'h2F);
    acc(1'b1, PPC_OFF_DATA, 32'h0000_0005, 32'h0, 1'b0);
    acc(1'b0, PPC_OFF_DATA, 32'h0, 32'h0000_0025, 1'b0);
    acc(1'b1, PPC_OFF_DIRECTION, 32'h0000_003F, 32'h0, 1'b0);
    pads(6'h20, 6'h1F, 6'h1F, 6'h1F, 6'h2F);
    check("out_val", 32'(pad.out_val), 32'h0000_0005);
    acc(1'b0, PPC_OFF_EFF_OUT, 32'h0, 32'h0000_001F, 1'b0);
    @(posedge pclk);
    share.periph_en <= 6'h01;
    pads(6'h21, 6'h1E, 6'h1E, 6'h1E, 6'h2F);
    @(posedge pclk);
    share.analog_en <= 6'h22;
    pads(6'h01, 6'h1C, 6'h1C, 6'h1C, 6'h0D);
    acc(1'b1, 8'h24, 32'h0, 32'h0, 1'b1);
    acc(1'b1, PPC_OFF_EFF_PULLUP, 32'h0000_00FF, 32'h0, 1'b1);
    acc(1'b0, PPC_OFF_EFF_PULLUP, 32'h0, 32'h0000_0001, 1'b0);
    strb = 4'h0;
    acc(1'b1, PPC_OFF_PULLUP, 32'h0, 32'h0, 1'b0);
    strb = 4'hF;
    acc(1'b0, PPC_OFF_PULLUP, 32'h0, 32'h0000_003F, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    share <= '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pads(6'h00, 6'h00, 6'h00, 6'h00, 6'h2F);
    acc(1'b0, PPC_OFF_PULLUP, 32'h0, 32'h0, 1'b0);
    stop_test();
  end
endmodule : ppc_top_tb_top
